// File: acd_top.sv
// ata command decoder with smart, security and flash upkeep sequencing
// Contract
// RL1 - The device recognises the read, write, verify, seek and other supported opcodes.
// RL2 - The device supports the security group and erase-unit wipes all user data.
// RL3 - The smart opcode returns drive health data to the host.
// RL4 - Under smart, the nine listed subcommands are decoded.
// RL5 - Records hold id, two flag bytes, value, worst and seven raw bytes lsb first.
// RL6 - Attributes are reported under their fixed identifiers.
// RL7 - The set includes bad block, erase count, power-on and power cycle counts.
// RL8 - Ecc corrects up to forty bits per kilobyte and flags more as uncorrectable.
// RL9 - A detected bad block is relocated to a free block with errors corrected.
// RL10 - On power loss during writes, several metadata save passes are run.
// RL11 - At power-up the map is recovered and programmed blocks are rechecked first.
// RL12 - Unsupported opcodes or subcommands are aborted without touching data.
`timescale 1ns/1ns
module acd_top
	import acd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// command from the transport
	input wire logic cmd_valid,
	input wire acd_cmd_t cmd,
	output logic cmd_ready,
	// answer to the transport
	output acd_resp_t resp,
	output logic resp_valid,
	// flash-side events
	input wire acd_ecc_t ecc,
	input wire logic ecc_valid,
	input wire logic bad_block,
	input wire logic power_loss,
	input wire logic flash_done,
	// flash-side requests
	output logic relocate_req,
	output logic meta_save_req,
	output logic map_recover_req,
	output logic block_scan_req,
	output logic erase_all_req,
	output logic xfer_req,
	// attribute counters
	input wire logic [55:0] attr_raw [ATTR_NUM],
	input wire logic [7:0] attr_value [ATTR_NUM],
	input wire logic [7:0] attr_worst [ATTR_NUM],
	input wire logic [7:0] attr_thresh [ATTR_NUM]
);
	typedef enum logic [2:0] {
		ST_RECOVER, ST_SCAN, ST_IDLE, ST_BUSY, ST_SEND, ST_RELOC, ST_SAVE
	} acd_st_t;

	acd_st_t st_q, st_d;
	acd_act_t act;
	logic [3:0] idx_q, idx_d;
	logic [3:0] sel_q, sel_d;
	logic [2:0] pass_q, pass_d;
	logic smart_on_q, smart_on_d;
	logic thr_q, thr_d;
	acd_resp_t resp_q, resp_d;
	logic rv_q, rv_d;
	logic [7:0] rec [REC_BYTES];
	logic health_bad;
	logic reloc_pend_q, reloc_pend_d;

	// ---------------------------------------------------------------
	// opcode classification
	// ---------------------------------------------------------------
	always_comb begin
		act = ACD_ACT_ABORT; // [RL12]
		if (cmd.opcode[7:4] == OP_SEEK_HI) begin
			act = ACD_ACT_CTRL; // [RL1]
		end else begin
			case (cmd.opcode)
				OP_RD_DMA, OP_RD_DMA_EXT, OP_RD_FPDMA, OP_WR_DMA, OP_WR_DMA_EXT,
				OP_WR_FPDMA, OP_RD_SEC0, OP_RD_SEC1, OP_WR_SEC0, OP_WR_SEC1,
				OP_VFY0, OP_VFY1, OP_RD_MULT, OP_WR_MULT, OP_RD_LOG_DMA,
				OP_RD_LOG_EXT, OP_WR_LOG_DMA, OP_WR_LOG_EXT: act = ACD_ACT_XFER; // [RL1]
				OP_CHK_PWR, OP_DIAG, OP_FLUSH, OP_IDENT, OP_IDLE, OP_IDLE_IMM,
				OP_INIT_PAR, OP_RECAL, OP_SET_FEAT, OP_SET_MULT, OP_SLEEP,
				OP_STANDBY, OP_STBY_IMM, OP_SEC_SETPW, OP_SEC_UNLOCK,
				OP_SEC_ERPREP, OP_SEC_FREEZE, OP_SEC_DISPW: act = ACD_ACT_CTRL; // [RL2]
				OP_SEC_ERUNIT: act = ACD_ACT_ERASE; // [RL2]
				OP_SMART: begin
					case (cmd.feature)
						SC_RD_DATA, SC_RD_THR, SC_AUTOSAVE, SC_OFFLINE, SC_RD_LOG,
						SC_WR_LOG, SC_ENABLE, SC_DISABLE, SC_STATUS: act = ACD_ACT_SMART; // [RL4]
						default: act = ACD_ACT_ABORT; // [RL12]
					endcase
				end
				default: act = ACD_ACT_ABORT;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// record formatting and health
	// ---------------------------------------------------------------
	acd_rec_fmt u_fmt (
		.attr_id(ATTR_ID[sel_q]), // [RL6] [RL7]
		.flags(REC_FLAGS_RST),
		.value(thr_q ? attr_thresh[sel_q] : attr_value[sel_q]),
		.worst(attr_worst[sel_q]),
		.raw(thr_q ? 56'h0000_0000_0000_00 : attr_raw[sel_q]),
		.rec(rec)
	);

	always_comb begin
		health_bad = 1'b0;
		for (int i = 0; i < ATTR_NUM; i++) begin
			if (attr_thresh[i] != 8'h00 && attr_value[i] <= attr_thresh[i]) begin
				health_bad = 1'b1; // [RL3]
			end
		end
	end

	// ---------------------------------------------------------------
	// main sequencer
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		sel_d = sel_q;
		pass_d = pass_q;
		smart_on_d = smart_on_q;
		thr_d = thr_q;
		resp_d = resp_q;
		rv_d = 1'b0;
		reloc_pend_d = reloc_pend_q;
		case (st_q)
			ST_RECOVER: if (flash_done) st_d = ST_SCAN; // [RL11]
			ST_SCAN: if (flash_done) st_d = ST_IDLE; // [RL11]
			ST_IDLE: begin
				if (reloc_pend_q) begin
					st_d = ST_RELOC;
				end else if (cmd_valid) begin
					resp_d = '0;
					case (act)
						ACD_ACT_XFER, ACD_ACT_ERASE: st_d = ST_BUSY;
						ACD_ACT_SMART: begin
							if (!smart_on_q && cmd.feature != SC_ENABLE) begin
								resp_d.abort = 1'b1;
								rv_d = 1'b1;
							end else begin
								case (cmd.feature)
									SC_RD_DATA, SC_RD_THR: begin
										thr_d = (cmd.feature == SC_RD_THR);
										sel_d = (cmd.attr_sel < 8'(ATTR_NUM)) ? cmd.attr_sel[3:0] : 4'h0000;
										idx_d = 4'h0000;
										st_d = ST_SEND; // [RL3]
									end
									SC_ENABLE, SC_DISABLE: begin
										smart_on_d = (cmd.feature == SC_ENABLE);
										resp_d.ok = 1'b1;
										rv_d = 1'b1;
									end
									SC_STATUS: begin
										resp_d.ok = 1'b1;
										resp_d.health_bad = health_bad; // [RL3]
										rv_d = 1'b1;
									end
									default: begin
										resp_d.ok = 1'b1;
										rv_d = 1'b1;
									end
								endcase
							end
						end
						ACD_ACT_CTRL: begin
							resp_d.ok = 1'b1;
							rv_d = 1'b1;
						end
						default: begin
							resp_d.abort = 1'b1; // [RL12]
							rv_d = 1'b1;
						end
					endcase
				end
			end
			ST_BUSY: if (flash_done) begin
				resp_d.ok = 1'b1;
				rv_d = 1'b1;
				st_d = ST_IDLE;
			end
			ST_SEND: begin
				resp_d.ok = 1'b1;
				resp_d.data = rec[idx_q]; // [RL5]
				resp_d.last = (idx_q == 4'(REC_BYTES - 1));
				rv_d = 1'b1;
				idx_d = idx_q + 4'h0001;
				if (idx_q == 4'(REC_BYTES - 1)) st_d = ST_IDLE;
			end
			ST_RELOC: if (flash_done) begin
				reloc_pend_d = 1'b0; // [RL9]
				st_d = ST_IDLE;
			end
			ST_SAVE: if (flash_done && pass_q != 3'h0000) pass_d = pass_q - 3'h0001; // [RL10]
			default: st_d = ST_IDLE;
		endcase
		// a new event in the clearing cycle keeps relocation pending
		if (bad_block) reloc_pend_d = 1'b1; // [RL9]
		if (ecc_valid && (ecc.uncorrectable || ecc.err_bits > 10'(ECC_MAX_BITS))) begin
			reloc_pend_d = 1'b1; // [RL8]
		end
		if (power_loss && st_q != ST_SAVE) begin
			st_d = ST_SAVE; // [RL10]
			pass_d = META_SAVE_PASSES;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= ST_RECOVER;
			idx_q <= 4'h0000;
			sel_q <= 4'h0000;
			pass_q <= 3'h0000;
			smart_on_q <= 1'b1;
			thr_q <= 1'b0;
			resp_q <= '0;
			rv_q <= 1'b0;
			reloc_pend_q <= 1'b0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			sel_q <= sel_d;
			pass_q <= pass_d;
			smart_on_q <= smart_on_d;
			thr_q <= thr_d;
			resp_q <= resp_d;
			rv_q <= rv_d;
			reloc_pend_q <= reloc_pend_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cmd_ready = (st_q == ST_IDLE) && !reloc_pend_q;
	assign resp = resp_q;
	assign resp_valid = rv_q;
	assign map_recover_req = (st_q == ST_RECOVER); // [RL11]
	assign block_scan_req = (st_q == ST_SCAN); // [RL11]
	assign relocate_req = (st_q == ST_RELOC); // [RL9]
	assign meta_save_req = (st_q == ST_SAVE) && (pass_q != 3'h0000); // [RL10]
	assign erase_all_req = (st_q == ST_BUSY) && (cmd.opcode == OP_SEC_ERUNIT); // [RL2]
	assign xfer_req = (st_q == ST_BUSY) && (cmd.opcode != OP_SEC_ERUNIT);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic take_ok;
	assign take_ok = cmd_valid && cmd_ready && !power_loss;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_bad_op;
		take_ok && act == ACD_ACT_ABORT;
	endsequence
	sequence s_smart_rd;
		take_ok && cmd.opcode == OP_SMART && smart_on_q
			&& cmd.feature == SC_RD_DATA;
	endsequence

	bad_op_abort_a: assert property (s_bad_op |=> resp_valid && resp.abort) // [RL12]
		else $error("unsupported opcode not aborted");
	bad_op_quiet_a: assert property (s_bad_op |=> !erase_all_req && !xfer_req) // [RL12]
		else $error("unsupported opcode touched data");
	seek_ok_a: assert property (take_ok && cmd.opcode[7:4] == OP_SEEK_HI
		|=> resp_valid && resp.ok) // [RL1]
		else $error("seek opcode not accepted");
	erase_start_a: assert property (take_ok && cmd.opcode == OP_SEC_ERUNIT
		|=> erase_all_req) // [RL2]
		else $error("erase unit did not start wipe");
	smart_first_a: assert property (disable iff (sys_rst || power_loss) s_smart_rd |=> ##1 resp_valid
		&& resp.data == ATTR_ID[$past(sel_q)]) // [RL6]
		else $error("record byte zero is not the id");
	smart_len_a: assert property (disable iff (sys_rst || power_loss)
		s_smart_rd |=> ##12 resp_valid && resp.last) // [RL5]
		else $error("record length wrong");
	status_ok_a: assert property (take_ok && cmd.opcode == OP_SMART
		&& smart_on_q && cmd.feature == SC_STATUS |=> resp_valid && resp.ok) // [RL3]
		else $error("return status not answered");
	save_start_a: assert property ($rose(power_loss) && st_q != ST_SAVE
		|=> meta_save_req && pass_q == META_SAVE_PASSES) // [RL10]
		else $error("metadata save not started");
	reloc_go_a: assert property (bad_block && st_q == ST_IDLE && !power_loss
		&& !reloc_pend_q && !cmd_valid
		|=> ##1 relocate_req || st_q == ST_SAVE) // [RL9]
		else $error("bad block not relocated");
	boot_order_a: assert property (block_scan_req |-> !cmd_ready) // [RL11]
		else $error("service before recovery done");
	scan_after_map_a: assert property ($rose(block_scan_req) |-> $past(map_recover_req)) // [RL11]
		else $error("block scan without map recovery");
	ecc_over_a: assert property (ecc_valid && ecc.err_bits > 10'(ECC_MAX_BITS) // [RL8]
		|=> reloc_pend_q)
		else $error("uncorrectable chunk not queued for relocation");
endmodule

// File: acd_pkg.sv
// shared constants and types for the ata command and smart decoder
package acd_pkg;
	// ---------------------------------------------------------------
	// command opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_RD_DMA = 8'h00C8;
	localparam logic [7:0] OP_RD_DMA_EXT = 8'h0025;
	localparam logic [7:0] OP_RD_FPDMA = 8'h0060;
	localparam logic [7:0] OP_WR_DMA = 8'h00CA;
	localparam logic [7:0] OP_WR_DMA_EXT = 8'h0035;
	localparam logic [7:0] OP_WR_FPDMA = 8'h0061;
	localparam logic [7:0] OP_RD_SEC0 = 8'h0020;
	localparam logic [7:0] OP_RD_SEC1 = 8'h0021;
	localparam logic [7:0] OP_WR_SEC0 = 8'h0030;
	localparam logic [7:0] OP_WR_SEC1 = 8'h0031;
	localparam logic [7:0] OP_VFY0 = 8'h0040;
	localparam logic [7:0] OP_VFY1 = 8'h0041;
	localparam logic [3:0] OP_SEEK_HI = 4'h0007;
	localparam logic [7:0] OP_CHK_PWR = 8'h00E5;
	localparam logic [7:0] OP_DIAG = 8'h0090;
	localparam logic [7:0] OP_FLUSH = 8'h00E7;
	localparam logic [7:0] OP_IDENT = 8'h00EC;
	localparam logic [7:0] OP_IDLE = 8'h00E3;
	localparam logic [7:0] OP_IDLE_IMM = 8'h00E1;
	localparam logic [7:0] OP_INIT_PAR = 8'h0091;
	localparam logic [7:0] OP_RD_LOG_DMA = 8'h0047;
	localparam logic [7:0] OP_RD_LOG_EXT = 8'h002F;
	localparam logic [7:0] OP_RD_MULT = 8'h00C4;
	localparam logic [7:0] OP_RECAL = 8'h0010;
	localparam logic [7:0] OP_SET_FEAT = 8'h00EF;
	localparam logic [7:0] OP_SET_MULT = 8'h00C6;
	localparam logic [7:0] OP_SLEEP = 8'h00E6;
	localparam logic [7:0] OP_STANDBY = 8'h00E2;
	localparam logic [7:0] OP_STBY_IMM = 8'h00E0;
	localparam logic [7:0] OP_WR_LOG_DMA = 8'h0057;
	localparam logic [7:0] OP_WR_LOG_EXT = 8'h003F;
	localparam logic [7:0] OP_WR_MULT = 8'h00C5;
	localparam logic [7:0] OP_SMART = 8'h00B0;
	localparam logic [7:0] OP_SEC_SETPW = 8'h00F1;
	localparam logic [7:0] OP_SEC_UNLOCK = 8'h00F2;
	localparam logic [7:0] OP_SEC_ERPREP = 8'h00F3;
	localparam logic [7:0] OP_SEC_ERUNIT = 8'h00F4;
	localparam logic [7:0] OP_SEC_FREEZE = 8'h00F5;
	localparam logic [7:0] OP_SEC_DISPW = 8'h00F6;
	// ---------------------------------------------------------------
	// smart subcommands
	// ---------------------------------------------------------------
	localparam logic [7:0] SC_RD_DATA = 8'h00D0;
	localparam logic [7:0] SC_RD_THR = 8'h00D1;
	localparam logic [7:0] SC_AUTOSAVE = 8'h00D2;
	localparam logic [7:0] SC_OFFLINE = 8'h00D4;
	localparam logic [7:0] SC_RD_LOG = 8'h00D5;
	localparam logic [7:0] SC_WR_LOG = 8'h00D6;
	localparam logic [7:0] SC_ENABLE = 8'h00D8;
	localparam logic [7:0] SC_DISABLE = 8'h00D9;
	localparam logic [7:0] SC_STATUS = 8'h00DA;
	// ---------------------------------------------------------------
	// attribute identifiers and record layout
	// ---------------------------------------------------------------
	localparam int ATTR_NUM = 12;
	localparam logic [7:0] ATTR_ID [ATTR_NUM] = '{8'h0009, 8'h000C, 8'h00A3, 8'h00A4,
		8'h00A5, 8'h00A6, 8'h00A7, 8'h00A8, 8'h00AF, 8'h00C0, 8'h00C2, 8'h00F1};
	localparam int REC_BYTES = 12;
	localparam int REC_ID_POS = 0;
	localparam int REC_FLAG_POS = 1;
	localparam int REC_VAL_POS = 3;
	localparam int REC_WORST_POS = 4;
	localparam int REC_RAW_POS = 5;
	localparam int RAW_BYTES = 7;
	localparam logic [15:0] REC_FLAGS_RST = 16'h0000;
	// ---------------------------------------------------------------
	// ecc and power-loss figures
	// ---------------------------------------------------------------
	localparam int ECC_MAX_BITS = 40;
	localparam int ECC_CHUNK_BYTES = 1024;
	localparam logic [2:0] META_SAVE_PASSES = 3'h0003;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ACD_ACT_NONE, ACD_ACT_XFER, ACD_ACT_SMART, ACD_ACT_ERASE,
		ACD_ACT_CTRL, ACD_ACT_ABORT
	} acd_act_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] feature;
		logic [7:0] attr_sel;
	} acd_cmd_t;
	typedef struct packed {
		logic ok;
		logic abort;
		logic health_bad;
		logic [7:0] data;
		logic last;
	} acd_resp_t;
	typedef struct packed {
		logic [9:0] err_bits;
		logic uncorrectable;
	} acd_ecc_t;
endpackage

// File: acd_rec_fmt.sv
// formats one smart attribute record into a byte array
`timescale 1ns/1ns
module acd_rec_fmt
	import acd_pkg::*;
(
	// attribute content
	input wire logic [7:0] attr_id,
	input wire logic [15:0] flags,
	input wire logic [7:0] value,
	input wire logic [7:0] worst,
	input wire logic [55:0] raw,
	// formatted record
	output logic [7:0] rec [REC_BYTES]
);
	// ---------------------------------------------------------------
	// byte placement
	// ---------------------------------------------------------------
	always_comb begin
		rec[REC_ID_POS] = attr_id; // [RL5]
		rec[REC_FLAG_POS] = flags[7:0]; // [RL5]
		rec[REC_FLAG_POS + 1] = flags[15:8];
		rec[REC_VAL_POS] = value; // [RL5]
		rec[REC_WORST_POS] = worst;
		for (int i = 0; i < RAW_BYTES; i++) begin
			rec[REC_RAW_POS + i] = raw[8 * i +: 8]; // [RL5]
		end
	end
endmodule

// File: acd_host_model.sv
// host-side command issuer and answer collector
`timescale 1ns/1ns
module acd_host_model
	import acd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// bench request
	input wire logic go,
	input wire acd_cmd_t go_cmd,
	// command to the device
	output logic cmd_valid,
	output acd_cmd_t cmd,
	input wire logic cmd_ready,
	// answers from the device
	input wire acd_resp_t resp,
	input wire logic resp_valid,
	output acd_resp_t rx_last,
	output logic [7:0] rx_bytes [12],
	output logic [4:0] rx_cnt
);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_valid <= 1'b0;
			cmd <= '0;
			rx_cnt <= 5'h0;
		end else begin
			if (go) begin
				// command held until the next request, the device decodes it while busy
				cmd_valid <= 1'b1;
				cmd <= go_cmd;
				rx_cnt <= 5'h0;
			end else if (cmd_valid && cmd_ready) begin
				cmd_valid <= 1'b0;
			end
			if (resp_valid) begin
				rx_last <= resp;
				if (rx_cnt < 5'hC) begin
					rx_bytes[rx_cnt] <= resp.data;
				end
				rx_cnt <= rx_cnt + 5'h1;
			end
		end
	end
endmodule

// File: testbench.sv
// self-checking bench for the ata command and smart decoder
`timescale 1ns/1ns
module testbench;
	import acd_pkg::*;
	logic clk_sys, sys_rst, go, ecc_valid, bad_block, power_loss, flash_done;
	logic cmd_valid, cmd_ready, resp_valid, relocate_req, meta_save_req, map_recover_req;
	logic block_scan_req, erase_all_req, xfer_req, saw_x, saw_e;
	acd_cmd_t go_cmd, cmd;
	acd_resp_t resp, rx_last;
	acd_ecc_t ecc;
	logic [55:0] attr_raw [ATTR_NUM];
	logic [7:0] attr_value [ATTR_NUM], attr_worst [ATTR_NUM], attr_thresh [ATTR_NUM];
	logic [7:0] rx_bytes [12];
	logic [4:0] rx_cnt;
	int error_cnt, total_checks;
	logic [7:0] ids [12] = '{8'h09, 8'h0C, 8'hA3, 8'hA4, 8'hA5, 8'hA6,
		8'hA7, 8'hA8, 8'hAF, 8'hC0, 8'hC2, 8'hF1};
	logic [7:0] xfer_ops [12] = '{8'hC8, 8'h25, 8'h60, 8'hCA, 8'h35, 8'h61,
		8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41};
	logic [7:0] ctrl_ops [28] = '{8'hE5, 8'h90, 8'hE7, 8'hEC, 8'hE3, 8'hE1, 8'h91, 8'h47,
		8'h2F, 8'hC4, 8'h10, 8'hEF, 8'hC6, 8'hE6, 8'hE2, 8'hE0, 8'h57, 8'h3F, 8'hC5,
		8'h70, 8'h7A, 8'h7F, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hF5};
	logic [7:0] bad_ops [4] = '{8'h00, 8'hFF, 8'hB1, 8'h8F};
	logic [7:0] sub_ok [7] = '{8'hD2, 8'hD4, 8'hD5, 8'hD6, 8'hD9, 8'hD8, 8'hDA};

	acd_top i_acd_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .resp(resp), .resp_valid(resp_valid), .ecc(ecc),
		.ecc_valid(ecc_valid), .bad_block(bad_block), .power_loss(power_loss),
		.flash_done(flash_done), .relocate_req(relocate_req), .meta_save_req(meta_save_req),
		.map_recover_req(map_recover_req), .block_scan_req(block_scan_req),
		.erase_all_req(erase_all_req), .xfer_req(xfer_req), .attr_raw(attr_raw),
		.attr_value(attr_value), .attr_worst(attr_worst), .attr_thresh(attr_thresh));
	acd_host_model i_acd_host_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go),
		.go_cmd(go_cmd), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp),
		.resp_valid(resp_valid), .rx_last(rx_last), .rx_bytes(rx_bytes), .rx_cnt(rx_cnt));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic pulse_done();
		flash_done <= 1'b1;
		@(posedge clk_sys);
		flash_done <= 1'b0;
		@(posedge clk_sys);
	endtask
	// issue one command, finish any flash step it asks for, wait for the first answer
	task automatic run(logic [7:0] op, logic [7:0] ft, logic [7:0] sel);
		int n;
		logic fd;
		saw_x = 1'b0;
		saw_e = 1'b0;
		fd = 1'b0;
		n = 0;
		while (!cmd_ready && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		go <= 1'b1;
		go_cmd <= '{op, ft, sel};
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		n = 0;
		while (rx_cnt == 5'h0 && n < 100) begin
			@(posedge clk_sys);
			n++;
			saw_x |= xfer_req;
			saw_e |= erase_all_req;
			flash_done <= (xfer_req || erase_all_req) && !fd;
			fd |= xfer_req || erase_all_req;
		end
		chk("answer", 1, rx_cnt != 5'h0);
	endtask
	task automatic smart_rd(logic [7:0] sub, int k);
		int n;
		logic [7:0] e [12];
		logic [55:0] raw;
		run(OP_SMART, sub, k[7:0]);
		n = 0;
		while (rx_cnt < 5'hC && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		raw = (sub == SC_RD_DATA) ? attr_raw[k] : 56'h0;
		e[0] = ids[k];
		e[1] = 8'h00;
		e[2] = 8'h00;
		e[3] = (sub == SC_RD_DATA) ? attr_value[k] : attr_thresh[k];
		e[4] = attr_worst[k];
		for (int b = 0; b < 7; b++) begin
			e[5 + b] = raw[8 * b +: 8];
		end
		for (int b = 0; b < 12; b++) begin
			chk("record byte", e[b], rx_bytes[b]);
		end
		chk("last", 1, rx_last.last);
	endtask
	task automatic reloc(logic [1:0] how, logic exp);
		ecc <= '{(how == 2'h3) ? 10'h029 : 10'h028, how == 2'h1};
		ecc_valid <= how != 2'h2;
		bad_block <= how == 2'h2;
		@(posedge clk_sys);
		ecc_valid <= 1'b0;
		bad_block <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("relocate_req", exp, relocate_req);
		chk("cmd_ready", !exp, cmd_ready);
		if (exp) begin
			pulse_done();
		end
		@(posedge clk_sys);
		chk("relocate_req", 0, relocate_req);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_powerup();
		@(posedge clk_sys);
		chk("map_recover_req", 1, map_recover_req);
		chk("cmd_ready", 0, cmd_ready);
		pulse_done();
		chk("block_scan_req", 1, block_scan_req);
		chk("cmd_ready", 0, cmd_ready);
		pulse_done();
		chk("cmd_ready", 1, cmd_ready);
	endtask
	task automatic t_opcodes();
		foreach (xfer_ops[i]) begin
			run(xfer_ops[i], 8'h00, 8'h00);
			chk("xfer_req", 1, saw_x);
			chk("ok", 1, rx_last.ok);
		end
		foreach (ctrl_ops[i]) begin
			run(ctrl_ops[i], 8'h00, 8'h00);
			chk("erase_all_req", ctrl_ops[i] == OP_SEC_ERUNIT, saw_e);
			chk("ok", 1, rx_last.ok);
		end
		foreach (bad_ops[i]) begin
			run(bad_ops[i], 8'h00, 8'h00);
			chk("abort", 1, rx_last.abort);
			chk("flash request", 0, saw_x | saw_e);
		end
	endtask
	task automatic t_smart();
		for (int k = 0; k < ATTR_NUM; k++) begin
			smart_rd(SC_RD_DATA, k);
		end
		smart_rd(SC_RD_THR, 5);
		foreach (sub_ok[i]) begin
			run(OP_SMART, sub_ok[i], 8'h00);
			chk("ok", 1, rx_last.ok);
		end
		run(OP_SMART, 8'hD3, 8'h00);
		chk("abort", 1, rx_last.abort);
		run(OP_SMART, SC_DISABLE, 8'h00);
		run(OP_SMART, SC_RD_DATA, 8'h00);
		chk("abort", 1, rx_last.abort);
		run(OP_SMART, SC_ENABLE, 8'h00);
		chk("ok", 1, rx_last.ok);
		run(OP_SMART, SC_STATUS, 8'h00);
		chk("health_bad", 0, rx_last.health_bad);
		attr_value[3] <= attr_thresh[3];
		run(OP_SMART, SC_STATUS, 8'h00);
		chk("health_bad", 1, rx_last.health_bad);
		attr_value[3] <= 8'h67;
	endtask
	task automatic t_loss();
		power_loss <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("meta_save_req", 1, meta_save_req);
		chk("cmd_ready", 0, cmd_ready);
		for (int p = 0; p < 2; p++) begin
			pulse_done();
			chk("meta_save_req", 1, meta_save_req);
		end
		pulse_done();
		chk("meta_save_req", 0, meta_save_req);
		power_loss <= 1'b0;
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_powerup();
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		error_cnt = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		{go, ecc_valid, bad_block, power_loss, flash_done} = 5'h0;
		go_cmd = '0;
		ecc = '0;
		for (int i = 0; i < ATTR_NUM; i++) begin
			attr_raw[i] = 56'h11_2233_4455_6677 + 56'(i);
			attr_value[i] = 8'h64 + 8'(i);
			attr_worst[i] = 8'h50 + 8'(i);
			attr_thresh[i] = 8'h0A + 8'(i);
		end
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_powerup();
		t_opcodes();
		t_smart();
		reloc(2'h0, 1'b0);
		reloc(2'h1, 1'b1);
		reloc(2'h2, 1'b1);
		reloc(2'h3, 1'b1);
		t_loss();
		report_and_stop();
	end
endmodule
